// *** tmcs_pkg.sv ***
// constants for the timer 0 mode, gate and clock-source block
// What this block does
// - timer 0 mode from mode register bits 1:0
// - modes 00/01/10: 13-bit, 16-bit, 8-bit reload
// - timer 1 mode 11 holds timer 1 stopped
// - gate set: count needs gate input and run
// - gate clear: count needs run only
// - timer source: core clock over 4 or 12
// - counter source: count pin falling edges
package tmcs_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [3:0] TMCS_OFS_MODE  = 4'h0;
    localparam logic [3:0] TMCS_OFS_RUN   = 4'h1;
    localparam logic [3:0] TMCS_OFS_RATE  = 4'h2;
    localparam logic [3:0] TMCS_OFS_T0_LO = 4'h3;
    localparam logic [3:0] TMCS_OFS_T0_HI = 4'h4;
    localparam logic [3:0] TMCS_OFS_T1_LO = 4'h5;
    localparam logic [3:0] TMCS_OFS_T1_HI = 4'h6;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int TMCS_MODE_LOW_BIT  = 0;
    localparam int TMCS_MODE_HIGH_BIT = 1;
    localparam int TMCS_SRC_BIT       = 2;
    localparam int TMCS_GATE_BIT      = 3;
    localparam int TMCS_T1_MODE_LOW   = 4;
    localparam int TMCS_T1_MODE_HIGH  = 5;
    localparam int TMCS_RUN0_BIT      = 4;
    localparam int TMCS_RUN1_BIT      = 6;
    localparam int TMCS_RATE0_BIT     = 3;
    // ************************************************************
    // reset values, mode codes, divider counts
    // ************************************************************
    localparam logic [7:0] TMCS_RST_BYTE  = 8'h00;
    localparam logic [1:0] TMCS_MODE_13   = 2'h0;
    localparam logic [1:0] TMCS_MODE_16   = 2'h1;
    localparam logic [1:0] TMCS_MODE_8RL  = 2'h2;
    localparam logic [1:0] TMCS_MODE_STOP = 2'h3;
    localparam logic [3:0] TMCS_DIV_FAST  = 4'h4;
    localparam logic [3:0] TMCS_DIV_SLOW  = 4'hC;
endpackage : tmcs_pkg

// *** tmcs_tick_if.sv ***
// signals between the pin/tick front end and the timer core
`timescale 1ns/100ps
interface tmcs_tick_if;
    logic rate_fast;
    logic core_tick;
    logic pin_fall;
    logic gate_level;
    modport front (input rate_fast, output core_tick, output pin_fall, output gate_level);
    modport core  (output rate_fast, input core_tick, input pin_fall, input gate_level);
endinterface : tmcs_tick_if

// *** tmcs_front.sv ***
// pin synchronisers, count-pin edge detect and core clock prescaler
`timescale 1ns/100ps
module tmcs_front
    import tmcs_pkg::*;
(
    input  wire logic  i_core_clk,
    input  wire logic  i_rstn,
    input  wire logic  i_count_pin,
    input  wire logic  i_gate_pin,
    tmcs_tick_if.front tick
);
    logic [1:0] cnt_sync_reg, cnt_sync_next;
    logic [1:0] gate_sync_reg, gate_sync_next;
    logic       cnt_last_reg, cnt_last_next;
    logic [3:0] div_reg, div_next;
    logic [3:0] div_end;

    // ************************************************************
    // synchronisers and edge detect
    // ************************************************************
    always_comb begin
        cnt_sync_next  = {cnt_sync_reg[0], i_count_pin};
        gate_sync_next = {gate_sync_reg[0], i_gate_pin};
        cnt_last_next  = cnt_sync_reg[1];
    end

    // ************************************************************
    // prescaler
    // ************************************************************
    always_comb begin
        div_end = tick.rate_fast ? TMCS_DIV_FAST : TMCS_DIV_SLOW;
        // wrap also when the rate drops below the current count
        if (div_reg >= div_end - 4'h1) begin
            div_next = 4'h0;
        end else begin
            div_next = div_reg + 4'h1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_sync_reg  <= 2'h0;
            gate_sync_reg <= 2'h0;
            cnt_last_reg  <= 1'b0;
            div_reg       <= 4'h0;
        end else begin
            cnt_sync_reg  <= cnt_sync_next;
            gate_sync_reg <= gate_sync_next;
            cnt_last_reg  <= cnt_last_next;
            div_reg       <= div_next;
        end
    end

    assign tick.core_tick  = (div_reg >= div_end - 4'h1);
    assign tick.pin_fall   = cnt_last_reg & ~cnt_sync_reg[1];
    assign tick.gate_level = gate_sync_reg[1];
endmodule : tmcs_front

// *** tmcs_timer.sv ***
// timer 0 mode, gating and source select with timer 1 halt in mode 3
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
module tmcs_timer
    import tmcs_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rstn,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_timer_zero_count_pin,
    input  wire logic       i_external_gate_input,
    output logic            o_timer_zero_overflow,
    output logic            o_timer_one_halted
);
    logic [7:0] mode_reg, mode_next;
    logic [7:0] run_reg, run_next;
    logic [7:0] rate_reg, rate_next;
    logic [7:0] t0_lo_reg, t0_lo_next;
    logic [7:0] t0_hi_reg, t0_hi_next;
    logic [7:0] t1_lo_reg, t1_lo_next;
    logic [7:0] t1_hi_reg, t1_hi_next;
    logic [7:0] rdata_reg, rdata_next;
    logic       ovf_reg, ovf_next;
    logic       halt_reg, halt_next;
    logic [1:0] t0_mode;
    logic       t0_enable;
    logic       t0_step;
    logic       t1_step;
    logic [13:0] sum13;
    logic [16:0] sum16;
    logic [8:0]  sum8;
    logic [16:0] sum1;

    tmcs_tick_if tick ();

    tmcs_front u_front (
        .i_core_clk  (i_core_clk),
        .i_rstn      (i_rstn),
        .i_count_pin (i_timer_zero_count_pin),
        .i_gate_pin  (i_external_gate_input),
        .tick        (tick)
    );

    function automatic logic wr_hit(input logic [3:0] ofs);
        wr_hit = i_wr && (i_addr == ofs);
    endfunction : wr_hit

    // ************************************************************
    // count qualification
    // ************************************************************
    always_comb begin
        tick.rate_fast = rate_reg[TMCS_RATE0_BIT];
        t0_mode   = {mode_reg[TMCS_MODE_HIGH_BIT], mode_reg[TMCS_MODE_LOW_BIT]};
        // gate clear ignores the gate pin entirely
        t0_enable = run_reg[TMCS_RUN0_BIT]
                    & (~mode_reg[TMCS_GATE_BIT] | tick.gate_level);
        t0_step   = t0_enable & (mode_reg[TMCS_SRC_BIT] ? tick.pin_fall
                                                        : tick.core_tick);
        halt_next = {mode_reg[TMCS_T1_MODE_HIGH], mode_reg[TMCS_T1_MODE_LOW]}
                    == TMCS_MODE_STOP;
        t1_step   = run_reg[TMCS_RUN1_BIT] & tick.core_tick & ~halt_next;
    end

    // ************************************************************
    // timer 0 counting
    // ************************************************************
    always_comb begin
        sum13      = {1'b0, t0_hi_reg, t0_lo_reg[4:0]} + 14'h0001;
        sum16      = {1'b0, t0_hi_reg, t0_lo_reg} + 17'h00001;
        sum8       = {1'b0, t0_lo_reg} + 9'h001;
        t0_lo_next = t0_lo_reg;
        t0_hi_next = t0_hi_reg;
        ovf_next   = 1'b0;
        if (t0_step) begin
            unique case (t0_mode)
                TMCS_MODE_13: begin
                    // upper three prescaler bits are left as software wrote them
                    t0_lo_next = {t0_lo_reg[7:5], sum13[4:0]};
                    t0_hi_next = sum13[12:5];
                    ovf_next   = sum13[13];
                end
                TMCS_MODE_16: begin
                    t0_lo_next = sum16[7:0];
                    t0_hi_next = sum16[15:8];
                    ovf_next   = sum16[16];
                end
                TMCS_MODE_8RL: begin
                    t0_lo_next = sum8[8] ? t0_hi_reg : sum8[7:0];
                    ovf_next   = sum8[8];
                end
                TMCS_MODE_STOP: begin
                    // mode 3 of timer 0 is kept as a plain 8-bit wrap
                    t0_lo_next = sum8[7:0];
                    ovf_next   = sum8[8];
                end
            endcase
        end
        // a software write takes precedence over a count step
        if (wr_hit(TMCS_OFS_T0_LO)) begin
            t0_lo_next = i_wdata;
        end
        if (wr_hit(TMCS_OFS_T0_HI)) begin
            t0_hi_next = i_wdata;
        end
    end

    // ************************************************************
    // timer 1 count, only to show the mode 3 halt
    // ************************************************************
    always_comb begin
        sum1       = {1'b0, t1_hi_reg, t1_lo_reg} + 17'h00001;
        t1_lo_next = t1_step ? sum1[7:0] : t1_lo_reg;
        t1_hi_next = t1_step ? sum1[15:8] : t1_hi_reg;
        if (wr_hit(TMCS_OFS_T1_LO)) begin
            t1_lo_next = i_wdata;
        end
        if (wr_hit(TMCS_OFS_T1_HI)) begin
            t1_hi_next = i_wdata;
        end
    end

    // ************************************************************
    // register port
    // ************************************************************
    always_comb begin
        mode_next  = wr_hit(TMCS_OFS_MODE) ? i_wdata : mode_reg;
        run_next   = wr_hit(TMCS_OFS_RUN) ? i_wdata : run_reg;
        rate_next  = wr_hit(TMCS_OFS_RATE) ? i_wdata : rate_reg;
        rdata_next = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                TMCS_OFS_MODE:  rdata_next = mode_reg;
                TMCS_OFS_RUN:   rdata_next = run_reg;
                TMCS_OFS_RATE:  rdata_next = rate_reg;
                TMCS_OFS_T0_LO: rdata_next = t0_lo_reg;
                TMCS_OFS_T0_HI: rdata_next = t0_hi_reg;
                TMCS_OFS_T1_LO: rdata_next = t1_lo_reg;
                TMCS_OFS_T1_HI: rdata_next = t1_hi_reg;
                default:        rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_reg  <= TMCS_RST_BYTE;
            run_reg   <= TMCS_RST_BYTE;
            rate_reg  <= TMCS_RST_BYTE;
            t0_lo_reg <= TMCS_RST_BYTE;
            t0_hi_reg <= TMCS_RST_BYTE;
            t1_lo_reg <= TMCS_RST_BYTE;
            t1_hi_reg <= TMCS_RST_BYTE;
            rdata_reg <= TMCS_RST_BYTE;
            ovf_reg   <= 1'b0;
            halt_reg  <= 1'b0;
        end else begin
            mode_reg  <= mode_next;
            run_reg   <= run_next;
            rate_reg  <= rate_next;
            t0_lo_reg <= t0_lo_next;
            t0_hi_reg <= t0_hi_next;
            t1_lo_reg <= t1_lo_next;
            t1_hi_reg <= t1_hi_next;
            rdata_reg <= rdata_next;
            ovf_reg   <= ovf_next;
            halt_reg  <= halt_next;
        end
    end

    assign o_rdata               = rdata_reg;
    assign o_timer_zero_overflow = ovf_reg;
    assign o_timer_one_halted    = halt_reg;
endmodule : tmcs_timer

// *** tmcs_timer_monitor.sv ***
// assertion checker for the timer 0 mode, gate and source block
`timescale 1ns/100ps
module tmcs_timer_monitor
    import tmcs_pkg::*;
(
    input wire logic       i_core_clk,
    input wire logic       i_rstn,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       i_timer_zero_count_pin,
    input wire logic       i_external_gate_input,
    input wire logic       o_timer_zero_overflow,
    input wire logic       o_timer_one_halted
);
    logic [7:0] mode_reg, run_reg, rate_reg;
    // ****************************************
    // shadow of the control bytes
    // ****************************************
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            {mode_reg, run_reg, rate_reg} <= 24'h000000;
        end else if (i_wr) begin
            if (i_addr == TMCS_OFS_MODE) mode_reg <= i_wdata;
            if (i_addr == TMCS_OFS_RUN) run_reg <= i_wdata;
            if (i_addr == TMCS_OFS_RATE) rate_reg <= i_wdata;
        end
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    a_mode_readback: assert property ($past(i_rd && i_addr == TMCS_OFS_MODE)
        |-> o_rdata == $past(mode_reg)) else $error("mode byte read back wrong");
    a_unmapped_zero: assert property ($past(i_rd && i_addr > TMCS_OFS_T1_HI)
        |-> o_rdata == 8'h00) else $error("unmapped read not zero");
    a_rate_readback: assert property ($past(i_rd && i_addr == TMCS_OFS_RATE)
        |-> o_rdata[3] == $past(rate_reg[3])) else $error("rate bit read back wrong");
    // halted is registered, so one cycle of lag is allowed
    a_halt_follows_mode: assert property ($past(i_wr && i_addr == TMCS_OFS_MODE)
        |-> ##[0:1] o_timer_one_halted == (mode_reg[5:4] == TMCS_MODE_STOP))
        else $error("timer one halt wrong");
    a_overflow_pulse: assert property ($rose(o_timer_zero_overflow)
        |=> !o_timer_zero_overflow) else $error("overflow longer than one cycle");
    a_overflow_needs_run: assert property (o_timer_zero_overflow
        |-> $past(run_reg[TMCS_RUN0_BIT])) else $error("overflow without run");
    a_gate_blocks_count: assert property (o_timer_zero_overflow && $past(mode_reg[3])
        |-> $past(i_external_gate_input, 3) || $past(i_external_gate_input, 4))
        else $error("gated timer counted with gate low");
    // pin low first seen 3 edges before the pulse: 2 sync stages, then the count edge
    a_pin_edge_source: assert property (o_timer_zero_overflow && $past(mode_reg[2])
        |-> $past(i_timer_zero_count_pin, 4) && !$past(i_timer_zero_count_pin, 3))
        else $error("pin count without falling edge");
    c_gate_count: cover property (o_timer_zero_overflow && mode_reg[TMCS_GATE_BIT]);
    c_pin_count: cover property (o_timer_zero_overflow && mode_reg[TMCS_SRC_BIT]);
    c_halted: cover property ($rose(o_timer_one_halted));
endmodule : tmcs_timer_monitor
bind tmcs_timer tmcs_timer_monitor u_monitor (
    .i_core_clk             (i_core_clk),
    .i_rstn                 (i_rstn),
    .i_addr                 (i_addr),
    .i_wdata                (i_wdata),
    .i_wr                   (i_wr),
    .i_rd                   (i_rd),
    .o_rdata                (o_rdata),
    .i_timer_zero_count_pin (i_timer_zero_count_pin),
    .i_external_gate_input  (i_external_gate_input),
    .o_timer_zero_overflow  (o_timer_zero_overflow),
    .o_timer_one_halted     (o_timer_one_halted)
);

// *** tmcs_timer_test.sv ***
// self-checking bench for the timer 0 mode, gate and source block
`timescale 1ns/100ps
module tmcs_timer_test import tmcs_pkg::*;;
    logic       i_core_clk, i_rstn, i_wr, i_rd, o_timer_zero_overflow, o_timer_one_halted;
    logic       i_timer_zero_count_pin, i_external_gate_input;
    logic [3:0] i_addr;
    logic [7:0] i_wdata, o_rdata;
    int         miscompares = 0, total_checks = 0;
    tmcs_timer DUT (
        .i_core_clk             (i_core_clk),
        .i_rstn                 (i_rstn),
        .i_addr                 (i_addr),
        .i_wdata                (i_wdata),
        .i_wr                   (i_wr),
        .i_rd                   (i_rd),
        .o_rdata                (o_rdata),
        .i_timer_zero_count_pin (i_timer_zero_count_pin),
        .i_external_gate_input  (i_external_gate_input),
        .o_timer_zero_overflow  (o_timer_zero_overflow),
        .o_timer_one_halted     (o_timer_one_halted)
    );
    initial begin
        i_core_clk = 1'h0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    // ****************************************
    // bus cycles and compare
    // ****************************************
    task automatic conclude;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        {i_addr, i_wdata, i_wr} <= {a, d, 1'h1};
        @(posedge i_core_clk);
        i_wr <= 1'h0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        {i_addr, i_rd} <= {a, 1'h1};
        @(posedge i_core_clk);
        i_rd <= 1'h0;
        @(negedge i_core_clk);
        d = o_rdata;
    endtask : rd
    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk($sformatf("reg %0h", a), e, v);
    endtask : rchk
    task automatic run_for(input logic [7:0] r, input int n);
        wr(TMCS_OFS_RUN, r);
        repeat (n) @(posedge i_core_clk);
        wr(TMCS_OFS_RUN, 8'h00);
    endtask : run_for
    task automatic setup(input logic [7:0] m, input logic [7:0] lo, input logic [7:0] hi);
        wr(TMCS_OFS_MODE, m);
        wr(TMCS_OFS_T0_LO, lo);
        wr(TMCS_OFS_T0_HI, hi);
        wr(TMCS_OFS_RUN, 8'h10);
    endtask : setup
    // stops at the first pulse so the stop write lands before the next step
    task automatic ovf(input int n, output logic s);
        s = 1'h0;
        repeat (n) if (!s) begin
            @(negedge i_core_clk);
            s = (o_timer_zero_overflow === 1'h1);
        end
    endtask : ovf
    task automatic run_ovf(input logic [7:0] m, lo, hi, elo, ehi);
        logic s;
        setup(m, lo, hi);
        ovf(60, s);
        wr(TMCS_OFS_RUN, 8'h00);
        chk("overflow", 8'h01, {7'h00, s});
        rchk(TMCS_OFS_T0_LO, elo);
        rchk(TMCS_OFS_T0_HI, ehi);
    endtask : run_ovf
    task automatic t_regs;
        for (int a = 0; a < 9; a++) rchk(4'(a), 8'h00);
        wr(TMCS_OFS_MODE, 8'hA5);
        rchk(TMCS_OFS_MODE, 8'hA5);
        wr(4'h9, 8'hFF);
        rchk(4'h9, 8'h00);
    endtask : t_regs
    task automatic t_halt;
        logic [7:0] v;
        wr(TMCS_OFS_MODE, 8'h30);
        run_for(8'h40, 40);
        @(negedge i_core_clk);
        chk("halted", 8'h01, {7'h00, o_timer_one_halted});
        rchk(TMCS_OFS_T1_LO, 8'h00);
        wr(TMCS_OFS_MODE, 8'h00);
        run_for(8'h40, 40);
        rd(TMCS_OFS_T1_LO, v);
        chk("halted", 8'h00, {7'h00, o_timer_one_halted});
        chk("timer one runs", 8'h01, {7'h00, v != 8'h00});
    endtask : t_halt
    // prescaler phase at run start is free, so one step either way
    // rate set before run so the switch cannot add a wrap tick; run stands 124 edges
    task automatic t_rate(input logic [7:0] rt, input int e);
        logic [7:0] v;
        wr(TMCS_OFS_RATE, rt);
        setup(8'h01, 8'h00, 8'h00);
        run_for(8'h10, 120);
        rd(TMCS_OFS_T0_LO, v);
        chk("rate count", 8'h01, {7'h00, (int'(v) - e) inside {[-1:1]}});
    endtask : t_rate
    task automatic t_gate;
        logic s;
        setup(8'h09, 8'hFF, 8'hFF);
        ovf(40, s);
        chk("gate low overflow", 8'h00, {7'h00, s});
        @(posedge i_core_clk);
        i_external_gate_input <= 1'h1;
        ovf(40, s);
        wr(TMCS_OFS_RUN, 8'h00);
        i_external_gate_input <= 1'h0;
        chk("gate high overflow", 8'h01, {7'h00, s});
    endtask : t_gate
    task automatic t_pin;
        setup(8'h05, 8'hFC, 8'hFF);
        repeat (4) begin
            i_timer_zero_count_pin <= 1'h1;
            repeat (4) @(posedge i_core_clk);
            i_timer_zero_count_pin <= 1'h0;
            repeat (4) @(posedge i_core_clk);
        end
        wr(TMCS_OFS_RUN, 8'h00);
        rchk(TMCS_OFS_T0_LO, 8'h00);
        rchk(TMCS_OFS_T0_HI, 8'h00);
    endtask : t_pin
    initial begin
        {i_rstn, i_wr, i_rd, i_timer_zero_count_pin, i_external_gate_input} = 5'h00;
        {i_addr, i_wdata} = 12'h000;
        repeat (16) @(posedge i_core_clk);
        i_rstn <= 1'h1;
        t_regs;
        t_halt;
        t_rate(8'h00, 124 / TMCS_DIV_SLOW);
        t_rate(8'h08, 124 / TMCS_DIV_FAST);
        run_ovf(8'h00, 8'hFF, 8'hFF, 8'hE0, 8'h00);
        run_ovf(8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00);
        run_ovf(8'h02, 8'hFF, 8'hA5, 8'hA5, 8'hA5);
        run_ovf(8'h03, 8'hFF, 8'h5A, 8'h00, 8'h5A);
        t_gate;
        t_pin;
        conclude;
    end
    initial begin
        repeat (20000) @(posedge i_core_clk);
        miscompares++;
        conclude;
    end
endmodule : tmcs_timer_test
